// ===== inc/cta_pkg.sv
// package: register map, field layout and carrier types for the tx abort and id filter block
// ============================================================================
// Operation
// - writing one clears an empty flag
// - ack flags read-only, cleared with empty flag
// - ack reads one if aborted, zero if sent
// - software clears empty; controller sets after sending
// - successful abort also sets empty flag
// - empty flag and enable keep interrupt pending
// - empty flag set clears abort request
// - abort granted before start or after failure
// - software can only set abort requests
// - resets and soft reset hold tx registers
// - mode selects 32, 16, 8-bit or closed
// - closed filter accepts nothing
// - hit index updates on foreground copy
// - filter registers writable only in soft reset
// - error counters read-only copies
// - only accepted messages signal the cpu
// - code compared bitwise with identifier bytes
// - extended uses four pairs, standard two
// - mask one ignores, zero must match
package cta_pkg;

    // ========================================================================
    // register byte addresses
    localparam logic [5:0] ADDR_MODCTL   = 6'h00; // soft reset control
    localparam logic [5:0] ADDR_TXFLG    = 6'h04;
    localparam logic [5:0] ADDR_TXCTL    = 6'h08;
    localparam logic [5:0] ADDR_IDACC    = 6'h0C;
    localparam logic [5:0] ADDR_RXERR    = 6'h10;
    localparam logic [5:0] ADDR_TXERR    = 6'h14;
    localparam logic [5:0] ADDR_CODE0    = 6'h20; // code 0..3 at +4 steps
    localparam logic [5:0] ADDR_MASK0    = 6'h30; // mask 0..3 at +4 steps

    // ========================================================================
    // field positions
    localparam int ACK_LSB    = 4;    // tx flag: ack bits 6:4
    localparam int EMPTY_LSB  = 0;    // tx flag: empty bits 2:0
    localparam int REQ_LSB    = 4;    // tx control: abort req bits 6:4
    localparam int IEN_LSB    = 0;    // tx control: enables 2:0
    localparam int HIT_LSB    = 0;    // id control: hit bits 1:0
    localparam int MODE_LSB   = 4;    // id control: mode bits 5:4
    localparam int SFT_BIT    = 0;    // module control: soft reset bit

    // ========================================================================
    // reset values and bus response codes
    localparam logic [2:0] EMPTY_RST  = 3'h7;
    localparam logic [7:0] MODCTL_RST = 8'h01;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // filter layout select encodings
    typedef enum logic [1:0]
    {
        MODE_W32  = 2'h0,
        MODE_W16  = 2'h1,
        MODE_W8   = 2'h2,
        MODE_SHUT = 2'h3
    } cta_mode_t;

    // per-buffer events from the transmit engine
    typedef struct packed
    {
        logic [2:0] sent;     // message sent ok
        logic [2:0] aborted;  // abort granted (not started or failed)
    } cta_tx_evt_t;

    // incoming message offered by the background buffer
    typedef struct packed
    {
        logic        valid;   // one-cycle pulse
        logic        ext;     // extended identifier
        logic [31:0] id;      // identifier bytes 0..3, byte 0 in 31:24
    } cta_rx_msg_t;

endpackage : cta_pkg

// ===== src/cta_core.sv
// design: transmit handshake flags, acceptance filter and error counter view
`timescale 1ns/100ps
`default_nettype none

module cta_core
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // axi4-lite slave
    input  wire logic [5:0]           s_awaddr,
    input  wire logic                 s_awvalid,
    output var  logic                 s_awready,
    input  wire logic [31:0]          s_wdata,
    input  wire logic [3:0]           s_wstrb,
    input  wire logic                 s_wvalid,
    output var  logic                 s_wready,
    output var  logic [1:0]           s_bresp,
    output var  logic                 s_bvalid,
    input  wire logic                 s_bready,
    input  wire logic [5:0]           s_araddr,
    input  wire logic                 s_arvalid,
    output var  logic                 s_arready,
    output var  logic [31:0]          s_rdata,
    output var  logic [1:0]           s_rresp,
    output var  logic                 s_rvalid,
    input  wire logic                 s_rready,
    // transmit engine side
    input  wire cta_pkg::cta_tx_evt_t tx_evt,
    output var  logic [2:0]           tx_pending,
    output var  logic [2:0]           tx_abort_req,
    output var  logic                 tx_empty_irq,
    // receive side
    input  wire cta_pkg::cta_rx_msg_t rx_msg,
    input  wire logic                 fg_free,
    output var  logic                 fg_load,
    output var  logic [1:0]           fg_hit,
    // internal error counters and sleep state
    input  wire logic [7:0]           rx_err_cnt,
    input  wire logic [7:0]           tx_err_cnt,
    input  wire logic                 sleep_mode,
    output var  logic                 soft_reset
);

    // ========================================================================
    // state registers
    logic [7:0] modctl_reg;         // module control, soft reset bit
    logic [2:0] empty_reg;          // buffer empty flags
    logic [2:0] ack_reg;            // abort ack flags
    logic [2:0] req_reg;            // abort request bits
    logic [2:0] ien_reg;            // empty interrupt enables
    logic [1:0] mode_reg;           // filter layout select
    logic [1:0] hit_reg;            // filter hit index
    logic [7:0] code_reg [4];       // acceptance code bytes
    logic [7:0] mask_reg [4];       // acceptance mask bytes
    logic       aw_held_reg;        // write address taken
    logic       w_held_reg;         // write data taken
    logic [5:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    wire        sft = modctl_reg[cta_pkg::SFT_BIT];

    // ========================================================================
    // write channel: address and data accepted in either order
    wire        aw_take = s_awvalid && s_awready;
    wire        w_take  = s_wvalid && s_wready;
    wire        wr_go   = aw_held_reg && w_held_reg && !s_bvalid;
    wire        wr_lane = wstrb_reg[0];     // registers live in byte lane 0
    wire [7:0]  wbyte   = wdata_reg[7:0];
    wire        wr_mod  = wr_go && wr_lane && awaddr_reg == cta_pkg::ADDR_MODCTL;
    wire        wr_flg  = wr_go && wr_lane && awaddr_reg == cta_pkg::ADDR_TXFLG;
    wire        wr_ctl  = wr_go && wr_lane && awaddr_reg == cta_pkg::ADDR_TXCTL;
    wire        wr_idc  = wr_go && wr_lane && awaddr_reg == cta_pkg::ADDR_IDACC && sft;
    wire        wr_ok   = awaddr_reg inside {cta_pkg::ADDR_MODCTL, cta_pkg::ADDR_TXFLG,
                          cta_pkg::ADDR_TXCTL, cta_pkg::ADDR_IDACC, cta_pkg::ADDR_RXERR,
                          cta_pkg::ADDR_TXERR} || awaddr_reg[5:4] inside {2'h2, 2'h3};

    // channel handshake registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 6'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            s_awready   <= 1'b0;
            s_wready    <= 1'b0;
            s_bvalid    <= 1'b0;
            s_bresp     <= cta_pkg::RESP_OKAY;
        end
        else
        begin
            s_awready <= !aw_held_reg && !aw_take;
            s_wready  <= !w_held_reg && !w_take;
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_awaddr;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_wdata;
                wstrb_reg  <= s_wstrb;
            end
            if (wr_go)
            begin
                // unmapped addresses below 0x20 answer slave error; every address from 0x20 to 0x3F answers okay
                s_bvalid    <= 1'b1;
                s_bresp     <= wr_ok ? cta_pkg::RESP_OKAY : cta_pkg::RESP_SLV;
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // ========================================================================
    // module control: soft reset comes up set
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            modctl_reg <= cta_pkg::MODCTL_RST;
        else if (wr_mod)
            modctl_reg <= {7'h00, wbyte[cta_pkg::SFT_BIT]};
    end

    // ========================================================================
    // transmit flags; hardware set wins over software clear
    wire [2:0]  flg_clr  = wr_flg ? wbyte[cta_pkg::EMPTY_LSB +: 3] : 3'h0;
    wire [2:0]  grant    = tx_evt.aborted & req_reg & ~empty_reg;
    wire [2:0]  set_e    = (tx_evt.sent & ~empty_reg) | grant;
    wire [2:0]  req_set  = wr_ctl ? wbyte[cta_pkg::REQ_LSB +: 3] : 3'h0;

    wire [2:0]  empty_next = set_e | (empty_reg & ~flg_clr);
    // ack follows last completion; clears with empty flag
    wire [2:0]  ack_next   = grant | (ack_reg & ~flg_clr & ~(tx_evt.sent & ~empty_reg));
    // request set only by software, dropped by a new empty flag or by soft reset
    wire [2:0]  req_next   = (req_reg | req_set) & ~set_e;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            empty_reg <= cta_pkg::EMPTY_RST;
            ack_reg   <= 3'h0;
            req_reg   <= 3'h0;
            ien_reg   <= 3'h0;
        end
        else if (sft)
        begin
            // held in reset state while soft reset set
            empty_reg <= cta_pkg::EMPTY_RST;
            ack_reg   <= 3'h0;
            req_reg   <= 3'h0;
            ien_reg   <= 3'h0;
        end
        else
        begin
            empty_reg <= empty_next;
            ack_reg   <= ack_next;
            req_reg   <= req_next;
            if (wr_ctl)
                ien_reg <= wbyte[cta_pkg::IEN_LSB +: 3];
        end
    end

    // outputs to transmit engine, all registered
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_pending   <= 3'h0;
            tx_abort_req <= 3'h0;
            tx_empty_irq <= 1'b0;
            soft_reset   <= 1'b1;
        end
        else
        begin
            tx_pending   <= sft ? 3'h0 : ~empty_next;
            tx_abort_req <= sft ? 3'h0 : req_next;
            tx_empty_irq <= !sft && |(empty_next & (wr_ctl ? wbyte[2:0] : ien_reg));
            soft_reset   <= wr_mod ? wbyte[cta_pkg::SFT_BIT] : sft;
        end
    end

    // ========================================================================
    // acceptance filter
    logic [3:0] hits;                               // per-filter match
    wire  [31:0] code_w = {code_reg[0], code_reg[1], code_reg[2], code_reg[3]};
    wire  [31:0] mask_w = {mask_reg[0], mask_reg[1], mask_reg[2], mask_reg[3]};
    // mismatch bit is one only where a cared bit differs
    wire  [31:0] miss   = (rx_msg.id ^ code_w) & ~mask_w;
    // standard ids only use first two pairs
    wire  [31:0] miss_q = rx_msg.ext ? miss : {miss[31:16], 16'h0000};

    always_comb
    begin
        hits = 4'h0;
        case (cta_pkg::cta_mode_t'(mode_reg))
            cta_pkg::MODE_W32: hits = {3'h0, ~|miss_q};
            cta_pkg::MODE_W16: hits = {2'h0, ~|miss_q[15:0], ~|miss_q[31:16]};
            cta_pkg::MODE_W8:  hits = {~|miss_q[7:0], ~|miss_q[15:8],
                                       ~|miss_q[23:16], ~|miss_q[31:24]};
            cta_pkg::MODE_SHUT: hits = 4'h0;
            default:           hits = 4'h0;
        endcase
    end

    wire [1:0] hit_idx = hits[0] ? 2'h0 : hits[1] ? 2'h1 : hits[2] ? 2'h2 : 2'h3;
    // only accepted messages reach the cpu; others are overwritten
    wire       accept  = rx_msg.valid && |hits && fg_free;

    // filter registers, writable only in soft reset
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_flt
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    code_reg[gi] <= 8'h00;
                    mask_reg[gi] <= 8'h00;
                end
                else if (wr_go && wr_lane && sft)
                begin
                    if (awaddr_reg == cta_pkg::ADDR_CODE0 + 6'(4 * gi))
                        code_reg[gi] <= wbyte;
                    if (awaddr_reg == cta_pkg::ADDR_MASK0 + 6'(4 * gi))
                        mask_reg[gi] <= wbyte;
                end
            end
        end
    endgenerate

    // mode, hit index and foreground load
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_reg <= 2'h0;
            hit_reg  <= 2'h0;
            fg_load  <= 1'b0;
            fg_hit   <= 2'h0;
        end
        else
        begin
            if (wr_idc)
                mode_reg <= wbyte[cta_pkg::MODE_LSB +: 2];
            fg_load <= accept;
            if (accept)
            begin
                hit_reg <= hit_idx;
                fg_hit  <= hit_idx;
            end
        end
    end

    // ========================================================================
    // read channel, one cycle answer
    logic [7:0] rbyte;
    logic       rd_ok;
    always_comb
    begin
        rbyte = 8'h00;
        rd_ok = 1'b1;
        case (s_araddr)
            cta_pkg::ADDR_MODCTL: rbyte = modctl_reg;
            cta_pkg::ADDR_TXFLG:  rbyte = {1'b0, ack_reg, 1'b0, empty_reg};
            cta_pkg::ADDR_TXCTL:  rbyte = {1'b0, req_reg, 1'b0, ien_reg};
            cta_pkg::ADDR_IDACC:  rbyte = {2'h0, mode_reg, 2'h0, hit_reg};
            cta_pkg::ADDR_RXERR:  rbyte = rx_err_cnt;
            cta_pkg::ADDR_TXERR:  rbyte = tx_err_cnt;
            default:
            begin
                if (s_araddr[5:4] == 2'h2 && s_araddr[1:0] == 2'h0)
                    rbyte = code_reg[s_araddr[3:2]];
                else if (s_araddr[5:4] == 2'h3 && s_araddr[1:0] == 2'h0)
                    rbyte = mask_reg[s_araddr[3:2]];
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= cta_pkg::RESP_OKAY;
        end
        else
        begin
            s_arready <= !s_rvalid && !(s_arvalid && s_arready);
            if (s_arvalid && s_arready)
            begin
                s_rvalid <= 1'b1;
                s_rdata  <= {24'h000000, rbyte};
                s_rresp  <= rd_ok ? cta_pkg::RESP_OKAY : cta_pkg::RESP_SLV;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // ========================================================================
    // assertions
    property p_empty_clr;
        @(posedge clk) disable iff (!rst_b)
        (wr_flg && !sft && wbyte[0] && empty_reg[0] && !set_e[0]) |=> !empty_reg[0] && !ack_reg[0];
    endproperty
    a_empty_clr: assert property (p_empty_clr) else $error("empty flag not cleared");

    property p_zero_keep;
        @(posedge clk) disable iff (!rst_b)
        (wr_flg && !sft && !wbyte[1] && empty_reg[1]) |=> empty_reg[1];
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("zero write cleared flag");

    property p_sent;
        @(posedge clk) disable iff (!rst_b)
        (!sft && tx_evt.sent[0] && !empty_reg[0] && !grant[0]) |=> empty_reg[0] && !ack_reg[0];
    endproperty
    a_sent: assert property (p_sent) else $error("sent did not set empty");

    property p_abort;
        @(posedge clk) disable iff (!rst_b)
        (!sft && grant[2]) |=> empty_reg[2] && ack_reg[2] && !req_reg[2];
    endproperty
    a_abort: assert property (p_abort) else $error("abort not completed");

    property p_req_hold;
        @(posedge clk) disable iff (!rst_b)
        (!sft && req_reg[1] && !set_e[1]) |=> req_reg[1];
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("abort request dropped");

    property p_irq;
        @(posedge clk) disable iff (!rst_b)
        (!sft && |(empty_reg & ien_reg)) |-> tx_empty_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("empty interrupt missing");

    property p_sft_hold;
        @(posedge clk) disable iff (!rst_b)
        sft |=> (empty_reg == cta_pkg::EMPTY_RST && req_reg == 3'h0 && ien_reg == 3'h0);
    endproperty
    a_sft_hold: assert property (p_sft_hold) else $error("tx regs not held");

    property p_mode_lock;
        @(posedge clk) disable iff (!rst_b)
        !sft |=> $stable(mode_reg) && $stable(code_reg[0]) && $stable(mask_reg[3]);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("filter written outside soft reset");

    property p_closed;
        @(posedge clk) disable iff (!rst_b)
        mode_reg == 2'h3 |=> !fg_load;
    endproperty
    a_closed: assert property (p_closed) else $error("closed filter loaded");

    property p_hit;
        @(posedge clk) disable iff (!rst_b)
        accept |=> fg_load && hit_reg == $past(hit_idx);
    endproperty
    a_hit: assert property (p_hit) else $error("hit index not updated");

    c_abort: cover property (@(posedge clk) disable iff (!rst_b) grant != 3'h0);
    c_sent:  cover property (@(posedge clk) disable iff (!rst_b) !sft && tx_evt.sent[0] && !empty_reg[0]);
    c_acc:   cover property (@(posedge clk) disable iff (!rst_b) accept && mode_reg == 2'h2);

endmodule : cta_core

`default_nettype wire

// ===== test/cta_node_model.sv
// partner model: transmit engine on the bus side, reporting sends and granted aborts
`timescale 1ns/100ps
`default_nettype none
// ====
module cta_node_model
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 go,           // start one attempt
    input  wire logic [1:0]           bsel,         // buffer index
    input  wire logic [3:0]           dly,          // cycles before the outcome
    input  wire logic [2:0]           tx_pending,
    input  wire logic [2:0]           tx_abort_req,
    output var  cta_pkg::cta_tx_evt_t tx_evt
);
    logic [3:0] cnt_reg;  // remaining wait
    logic       busy_reg; // attempt in flight
    logic [1:0] b_reg;    // buffer of the attempt
    // one attempt at a time; a pending abort wins because the frame has not started yet
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg  <= 4'h0;
            busy_reg <= 1'b0;
            b_reg    <= 2'h0;
            tx_evt   <= '0;
        end
        else
        begin
            tx_evt <= '0;
            if (go && !busy_reg)
            begin
                busy_reg <= 1'b1;
                cnt_reg  <= dly;
                b_reg    <= bsel;
            end
            else if (busy_reg && cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'h1;
            else if (busy_reg)
            begin
                busy_reg <= 1'b0;
                if (tx_abort_req[b_reg])
                    tx_evt.aborted[b_reg] <= 1'b1;
                else if (tx_pending[b_reg])
                    tx_evt.sent[b_reg] <= 1'b1;
            end
        end
    end
endmodule : cta_node_model
`default_nettype wire

// ===== test/tb.sv
// testbench: register bus, transmit handshake, acceptance filter, error counters
`timescale 1ns/100ps
`default_nettype none
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
// ====
module tb;
    logic clk, rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic [5:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rdat, id;
    logic [3:0] s_wstrb, dly;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, fg_free, fg_load, e;
    logic [1:0] s_bresp, s_rresp, resp, fg_hit, bsel, hit;
    logic [2:0] tx_pending, tx_abort_req, ex;
    logic tx_empty_irq, sleep_mode, soft_reset, go;
    logic [7:0] rx_err_cnt, tx_err_cnt, v;
    logic [7:0] code [4];
    logic [7:0] mask [4];
    cta_pkg::cta_tx_evt_t tx_evt;
    cta_pkg::cta_rx_msg_t rx_msg;
    int err_count, n_checks, cyc, seed;
    cta_core dut_u (.clk, .rst_b, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .tx_evt, .tx_pending,
        .tx_abort_req, .tx_empty_irq, .rx_msg, .fg_free, .fg_load, .fg_hit, .rx_err_cnt,
        .tx_err_cnt, .sleep_mode, .soft_reset);
    cta_node_model node_u (.clk, .rst_b, .go, .bsel, .dly, .tx_pending, .tx_abort_req,
        .tx_evt);
    // ====
    // clock, hang guard and verdict
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // ====
    // bus master: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        s_awaddr  <= a;
        s_wdata   <= {24'h0, d};
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end
        while (!s_bvalid);
        s_bready <= 1'b0;
        resp = s_bresp;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end
        while (!s_rvalid);
        s_rready <= 1'b0;
        rdat = s_rdata;
        resp = s_rresp;
    endtask : rd
    task automatic rchk(input logic [5:0] a, input logic [7:0] x);
        rd(a);
        `CK(rdat, {24'h0, x})
    endtask : rchk
    // one transmit attempt, waits for the buffer to come back empty
    task automatic send(input logic [1:0] b, input logic [3:0] d);
        @(posedge clk);
        go   <= 1'b1;
        bsel <= b;
        dly  <= d;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 30 && tx_pending[b]; i++) @(posedge clk);
    endtask : send
    // one message; id lines show the inverse outside the valid cycle
    task automatic rx();
        @(posedge clk);
        rx_msg <= {1'b1, e, id};
        @(posedge clk);
        rx_msg <= {1'b0, e, ~id};
        #1;
        `CK(fg_load, ex[2])
        if (ex[2]) `CK(fg_hit, ex[1:0])
    endtask : rx
    // expected {accept, hit}: bytes beyond the second always match for standard ids
    function automatic logic [2:0] exp_acc(input logic [1:0] md);
        logic [3:0] m;
        for (int n = 0; n < 4; n++)
            m[n] = (n > 1 && !e) || (((id[31-8*n -: 8] ^ code[n]) & ~mask[n]) == 8'h00);
        case (md)
            2'h0: return {&m, 2'h0};
            2'h1: return (m[0] & m[1]) ? 3'h4 : (m[2] & m[3]) ? 3'h5 : 3'h0;
            2'h2: return m[0] ? 3'h4 : m[1] ? 3'h5 : m[2] ? 3'h6 : m[3] ? 3'h7 : 3'h0;
            default: return 3'h0;
        endcase
    endfunction : exp_acc
    // ====
    // main sequence
    initial
    begin
        seed = 66168;
        {rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, go, sleep_mode} = '0;
        {s_awaddr, s_araddr, s_wdata, bsel, dly, rx_err_cnt, tx_err_cnt, hit} = '0;
        s_wstrb = 4'hF;
        fg_free = 1'b1;
        rx_msg  = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk(cta_pkg::ADDR_MODCTL, 8'h01);
        rchk(cta_pkg::ADDR_TXFLG, 8'h07);
        rchk(cta_pkg::ADDR_TXCTL, 8'h00);
        `CK(soft_reset, 1'b1)
        rd(6'h18);
        `CK(resp, cta_pkg::RESP_SLV)
        wr(6'h18, 8'h00);
        `CK(resp, cta_pkg::RESP_SLV)
        for (int md = 0; md < 4; md++)
        begin
            wr(cta_pkg::ADDR_MODCTL, 8'h01);
            wr(cta_pkg::ADDR_IDACC, 8'(md << 4));
            for (int n = 0; n < 4; n++)
            begin
                code[n] = 8'($random(seed));
                mask[n] = 8'($random(seed) & $random(seed)) | ((n == 1) ? 8'h07 : 8'h00);
                wr(cta_pkg::ADDR_CODE0 + 6'(4 * n), code[n]);
                wr(cta_pkg::ADDR_MASK0 + 6'(4 * n), mask[n]);
            end
            wr(cta_pkg::ADDR_MODCTL, 8'h00);
            `CK(soft_reset, 1'b0)
            wr(cta_pkg::ADDR_CODE0, ~code[0]);
            rchk(cta_pkg::ADDR_CODE0, code[0]);
            for (int k = 0; k < 12; k++)
            begin
                id = {code[0], code[1], code[2], code[3]};
                if (k > 0) id = id ^ ($random(seed) & $random(seed) & $random(seed) & $random(seed));
                e = 1'($random(seed));
                @(posedge clk);
                fg_free <= (k != 6);
                ex = exp_acc(2'(md));
                ex[2] = ex[2] & (k != 6);
                if (ex[2]) hit = ex[1:0];
                rx();
            end
            if (md != 3) rchk(cta_pkg::ADDR_IDACC, 8'(md << 4) | {6'h0, hit});
        end
        wr(cta_pkg::ADDR_TXCTL, 8'h07);
        `CK(tx_empty_irq, 1'b1)
        wr(cta_pkg::ADDR_TXFLG, 8'h00);
        rchk(cta_pkg::ADDR_TXFLG, 8'h07);
        wr(cta_pkg::ADDR_TXFLG, 8'h07); // all three buffers scheduled
        `CK(tx_pending, 3'h7)
        `CK(tx_empty_irq, 1'b0)
        send(2'h0, 4'h0);
        rchk(cta_pkg::ADDR_TXFLG, 8'h01);
        `CK(tx_empty_irq, 1'b1)
        wr(cta_pkg::ADDR_TXCTL, 8'h67); // abort requests for buffers 1 and 2, set in the same write as the enables
        wr(cta_pkg::ADDR_TXCTL, 8'h07);
        `CK(tx_abort_req, 3'h6)
        send(2'h1, 4'h9);
        rchk(cta_pkg::ADDR_TXFLG, 8'h23);
        `CK(tx_abort_req, 3'h4)
        wr(cta_pkg::ADDR_TXFLG, 8'h72);
        rchk(cta_pkg::ADDR_TXFLG, 8'h01);
        send(2'h2, 4'h3);
        send(2'h1, 4'h2);
        rchk(cta_pkg::ADDR_TXFLG, 8'h47);
        wr(cta_pkg::ADDR_TXFLG, 8'h07);
        wr(cta_pkg::ADDR_MODCTL, 8'h01);
        wr(cta_pkg::ADDR_TXCTL, 8'h17);
        rchk(cta_pkg::ADDR_TXFLG, 8'h07);
        rchk(cta_pkg::ADDR_TXCTL, 8'h00);
        `CK(soft_reset, 1'b1)
        repeat (3)
        begin
            v = 8'($random(seed));
            @(posedge clk);
            rx_err_cnt <= v;
            tx_err_cnt <= ~v;
            sleep_mode <= v[0];
            rchk(cta_pkg::ADDR_RXERR, v);
            `CK(resp, cta_pkg::RESP_OKAY)
            wr(cta_pkg::ADDR_TXERR, v);
            rchk(cta_pkg::ADDR_TXERR, ~v);
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
